// ### rtl/dmct_consts.svh
// register indices, field positions and reset values of the capture timer
`ifndef DMCT_CONSTS_SVH
`define DMCT_CONSTS_SVH

// register indices; byte address is four times the index
`define DMCT_IDX_LOW_MATCH 15'h7e18
`define DMCT_IDX_HIGH_MATCH 15'h7e19
`define DMCT_IDX_COUNT_LOW 15'h7f1a
`define DMCT_IDX_COUNT_HIGH 15'h7f1b
`define DMCT_IDX_RUN_FLAG 15'h7f1c
`define DMCT_IDX_CAPTURE 15'h7f1d
`define DMCT_IDX_CLOCK 15'h7f1e

// run_flag_control fields
`define DMCT_RF_HIGH_RUN 7
`define DMCT_RF_HIGH_FLAG 6
`define DMCT_RF_HIGH_IE 5
`define DMCT_RF_SPLIT 4
`define DMCT_RF_CAP_READ 3
`define DMCT_RF_RUN 2
`define DMCT_RF_LOW_FLAG 1
`define DMCT_RF_LOW_IE 0

// capture_control fields
`define DMCT_CC_SEL_HI 4
`define DMCT_CC_SEL_LO 3
`define DMCT_CC_HIGH_FLAG 2
`define DMCT_CC_LOW_FLAG 1
`define DMCT_CC_IE 0

// clock_prescale_control fields
`define DMCT_CK_SRC_HI 7
`define DMCT_CK_SRC_LO 6
`define DMCT_CK_EVT_PIN 5
`define DMCT_CK_LIMIT_HI 3
`define DMCT_CK_LIMIT_LO 0

// reset values
`define DMCT_RST_BYTE 8'h00
`define DMCT_RST_PRE 4'h0
`define DMCT_RST_SEL 2'h0
`define DMCT_RST_WORD 32'h0000_0000

`endif

// ### rtl/dmct_pkg.sv
// types shared by the capture timer
package dmct_pkg;
    typedef enum logic [1:0] {
        DMCT_SRC_SYS = 2'h0,
        DMCT_SRC_EVENT = 2'h1,
        DMCT_SRC_CRYSTAL = 2'h2,
        DMCT_SRC_CERAMIC = 2'h3
    } dmct_src_t;
endpackage

// ### rtl/dmct_timer.sv
// dual mode capture timer with apb register access
//
// Operation
// R1 - 4-bit prescaler matches limit, clears, resets stopped
// R2 - prescaler runs on run, or split high_run
// R3 - clock source picks system, oscillator or event
// R4 - low counter runs only with run bit
// R5 - high counter run: run, or high_run split
// R6 - low counts prescaler, split event mode counts pin
// R7 - high counts low overflow, split counts prescaler
// R8 - counters match buffers, reset on match or stop
// R9 - low buffer tracks stopped, loads at zero
// R10 - high buffer tracks stopped, loads at zero
// R11 - software writes match data once per period
// R12 - low capture trigger selected among four pins
// R13 - high capture trigger follows low or split table
// R14 - 16-bit capture latches both bytes together
// R15 - 16-bit period is match plus one times divider
// R16 - split periods per byte, events bypass prescaler
// R17 - match flag with enable requests interrupt
// R18 - capture flag with enable requests interrupt
// R19 - match flags set on wrap, cleared by zero
// R20 - capture read select returns captures at counters
// R21 - capture flags set per mode, software clears
// R22 - event pin select chooses second or third pin
// R23 - one interrupt output ors enabled flags
// R24 - pins synchronised, one edge per event
`include "dmct_consts.svh"

module dmct_timer #(
    parameter int ADDR_W = 17,
    parameter int PRE_W = 4,
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_event_pin_a,
    input wire logic ext_event_pin_b,
    input wire logic ext_event_pin_c,
    input wire logic ext_event_pin_d,
    input wire logic ext_event_pin_e,
    input wire logic ext_event_pin_f,
    input wire logic crystal_clock_src,
    input wire logic ceramic_clock_src,
    output logic irq
);

    localparam int NPIN = 8;

    // pin synchronisers and rising edge detect
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [NPIN-1:0] sync3_q;
    logic [NPIN-1:0] pin_edge;

    assign pin_raw = {ceramic_clock_src, crystal_clock_src, ext_event_pin_f, ext_event_pin_e,
                      ext_event_pin_d, ext_event_pin_c, ext_event_pin_b, ext_event_pin_a};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
            // a held level counts once: only the rising edge is an event
            assign pin_edge[gi] = sync2_q[gi] & ~sync3_q[gi]; // [R24]
        end
    endgenerate

    // registers
    logic [CNT_W-1:0] low_data_q;
    logic [CNT_W-1:0] high_data_q;
    logic high_run_q;
    logic high_flag_q;
    logic high_ie_q;
    logic split_q;
    logic cap_read_q;
    logic run_q;
    logic low_flag_q;
    logic low_ie_q;
    logic [1:0] cap_sel_q;
    logic high_cflag_q;
    logic low_cflag_q;
    logic cap_ie_q;
    dmct_pkg::dmct_src_t src_q;
    logic evt_pin_q;
    logic [PRE_W-1:0] limit_q;

    // apb decode
    logic [ADDR_W-1:0] a_low_match;
    logic [ADDR_W-1:0] a_high_match;
    logic [ADDR_W-1:0] a_count_low;
    logic [ADDR_W-1:0] a_count_high;
    logic [ADDR_W-1:0] a_run_flag;
    logic [ADDR_W-1:0] a_capture;
    logic [ADDR_W-1:0] a_clock;
    logic hit_low_match;
    logic hit_high_match;
    logic hit_count_low;
    logic hit_count_high;
    logic hit_run_flag;
    logic hit_capture;
    logic hit_clock;
    logic hit_any;
    logic wr_en;
    logic rd_setup;

    assign a_low_match = ADDR_W'({`DMCT_IDX_LOW_MATCH, 2'b00});
    assign a_high_match = ADDR_W'({`DMCT_IDX_HIGH_MATCH, 2'b00});
    assign a_count_low = ADDR_W'({`DMCT_IDX_COUNT_LOW, 2'b00});
    assign a_count_high = ADDR_W'({`DMCT_IDX_COUNT_HIGH, 2'b00});
    assign a_run_flag = ADDR_W'({`DMCT_IDX_RUN_FLAG, 2'b00});
    assign a_capture = ADDR_W'({`DMCT_IDX_CAPTURE, 2'b00});
    assign a_clock = ADDR_W'({`DMCT_IDX_CLOCK, 2'b00});
    assign hit_low_match = paddr == a_low_match;
    assign hit_high_match = paddr == a_high_match;
    assign hit_count_low = paddr == a_count_low;
    assign hit_count_high = paddr == a_count_high;
    assign hit_run_flag = paddr == a_run_flag;
    assign hit_capture = paddr == a_capture;
    assign hit_clock = paddr == a_clock;
    assign hit_any = hit_low_match | hit_high_match | hit_count_low | hit_count_high
                     | hit_run_flag | hit_capture | hit_clock;
    // only the low byte lane carries register data
    assign wr_en = psel & penable & pwrite & pstrb[0] & hit_any;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // prescaler
    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;
    logic pre_run;
    logic pre_src;
    logic evt_src;
    logic pre_match;

    assign pre_run = run_q | (split_q & high_run_q); // [R2]
    assign evt_src = evt_pin_q ? pin_edge[3] : pin_edge[2]; // [R22]
    assign pre_src = (src_q == dmct_pkg::DMCT_SRC_CRYSTAL) ? pin_edge[6]
                   : (src_q == dmct_pkg::DMCT_SRC_CERAMIC) ? pin_edge[7]
                   : (src_q == dmct_pkg::DMCT_SRC_EVENT && (evt_pin_q || !split_q)) ? evt_src
                   : 1'b1; // [R3]
    assign pre_match = pre_run & pre_src & (pre_q == limit_q); // [R1]
    assign pre_d = (!pre_run || pre_match) ? '0
                 : pre_src ? PRE_W'(pre_q + 1'b1) : pre_q; // [R1]

    // counters
    logic [CNT_W-1:0] cnt_l_q;
    logic [CNT_W-1:0] cnt_h_q;
    logic [CNT_W-1:0] cnt_l_d;
    logic [CNT_W-1:0] cnt_h_d;
    logic [CNT_W-1:0] buf_l_q;
    logic [CNT_W-1:0] buf_h_q;
    logic [CNT_W-1:0] buf_l_d;
    logic [CNT_W-1:0] buf_h_d;
    logic low_run;
    logic high_run;
    logic low_tick;
    logic high_tick;
    logic low_adv;
    logic high_adv;
    logic low_match;
    logic high_match;
    logic low_zero;
    logic high_zero;
    logic eq16;

    assign low_run = run_q; // [R4]
    assign high_run = split_q ? high_run_q : run_q; // [R5]
    // split event mode clocks the low counter straight from pin_edge[2], bypassing the prescaler
    assign low_tick = (split_q && src_q == dmct_pkg::DMCT_SRC_EVENT) ? pin_edge[2]
                    : pre_match; // [R6] [R16]
    assign low_adv = low_run & low_tick;
    assign high_tick = split_q ? pre_match : (low_adv & (&cnt_l_q)); // [R7]
    assign high_adv = high_run & high_tick;
    assign eq16 = {cnt_h_q, cnt_l_q} == {buf_h_q, buf_l_q};
    // 16-bit compare makes the period (hi*256+lo+1) low ticks
    assign low_match = low_adv & (split_q ? (cnt_l_q == buf_l_q) : eq16); // [R8] [R15]
    assign high_match = split_q ? (high_adv & (cnt_h_q == buf_h_q)) : low_match; // [R8]
    assign cnt_l_d = (!low_run || low_match) ? '0
                   : low_adv ? CNT_W'(cnt_l_q + 1'b1) : cnt_l_q; // [R8]
    assign cnt_h_d = (!high_run || high_match) ? '0
                   : high_adv ? CNT_W'(cnt_h_q + 1'b1) : cnt_h_q; // [R8]
    assign low_zero = low_match | (low_adv & (cnt_l_d == '0));
    assign high_zero = high_match | (high_adv & (cnt_h_d == '0));
    // buffers track the data while stopped and reload when their byte returns to zero, so a low-byte wrap can cut a 16-bit period short
    assign buf_l_d = (!low_run || low_zero) ? low_data_q : buf_l_q; // [R9]
    assign buf_h_d = (!high_run || high_zero) ? high_data_q : buf_h_q; // [R10]

    // captures
    logic [CNT_W-1:0] cap_l_q;
    logic [CNT_W-1:0] cap_h_q;
    logic [3:0] cap_l_pins;
    logic [3:0] cap_h_pins;
    logic cap_l_evt;
    logic cap_h_split;
    logic cap_h_evt;

    assign cap_l_pins = {pin_edge[5], pin_edge[4], pin_edge[2], pin_edge[0]};
    assign cap_h_pins = {pin_edge[4], pin_edge[5], pin_edge[3], pin_edge[1]};
    assign cap_l_evt = cap_l_pins[cap_sel_q]; // [R12]
    assign cap_h_split = cap_h_pins[cap_sel_q];
    assign cap_h_evt = split_q ? cap_h_split : cap_l_evt; // [R13] [R14]

    // flags: a hardware set in the same cycle as a clear wins
    logic wr_run_flag;
    logic wr_capture;
    logic low_flag_d;
    logic high_flag_d;
    logic low_cflag_d;
    logic high_cflag_d;
    logic irq_d;

    assign wr_run_flag = wr_en & hit_run_flag;
    assign wr_capture = wr_en & hit_capture;
    assign low_flag_d = (low_flag_q & ~(wr_run_flag & ~pwdata[`DMCT_RF_LOW_FLAG]))
                      | low_match; // [R19]
    assign high_flag_d = (high_flag_q & ~(wr_run_flag & ~pwdata[`DMCT_RF_HIGH_FLAG]))
                       | (split_q & high_match); // [R19]
    assign low_cflag_d = (low_cflag_q & ~(wr_capture & ~pwdata[`DMCT_CC_LOW_FLAG]))
                       | cap_l_evt; // [R21]
    assign high_cflag_d = (high_cflag_q & ~(wr_capture & ~pwdata[`DMCT_CC_HIGH_FLAG]))
                        | (split_q & cap_h_split); // [R21]
    assign irq_d = (low_flag_q & low_ie_q) | (high_flag_q & high_ie_q) // [R17]
                 | ((low_cflag_q | high_cflag_q) & cap_ie_q); // [R18] [R23]

    // read mux
    logic [7:0] rd_data;

    assign rd_data = hit_low_match ? low_data_q
                   : hit_high_match ? high_data_q
                   : hit_count_low ? (cap_read_q ? cap_l_q : cnt_l_q) // [R20]
                   : hit_count_high ? (cap_read_q ? cap_h_q : cnt_h_q) // [R20]
                   : hit_run_flag ? {high_run_q, high_flag_q, high_ie_q, split_q,
                                     cap_read_q, run_q, low_flag_q, low_ie_q}
                   : hit_capture ? {3'h0, cap_sel_q, high_cflag_q, low_cflag_q, cap_ie_q}
                   : hit_clock ? {src_q, evt_pin_q, 1'b0, limit_q}
                   : `DMCT_RST_BYTE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `DMCT_RST_WORD;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_data};
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_data_q <= `DMCT_RST_BYTE;
            high_data_q <= `DMCT_RST_BYTE;
            {high_run_q, high_ie_q, split_q, cap_read_q, run_q, low_ie_q} <= 6'h00;
            cap_sel_q <= `DMCT_RST_SEL;
            cap_ie_q <= 1'b0;
            src_q <= dmct_pkg::DMCT_SRC_SYS;
            evt_pin_q <= 1'b0;
            limit_q <= `DMCT_RST_PRE;
        end else if (wr_en) begin
            if (hit_low_match) begin
                low_data_q <= pwdata[7:0];
            end
            if (hit_high_match) begin
                high_data_q <= pwdata[7:0];
            end
            if (hit_run_flag) begin
                high_run_q <= pwdata[`DMCT_RF_HIGH_RUN];
                high_ie_q <= pwdata[`DMCT_RF_HIGH_IE];
                split_q <= pwdata[`DMCT_RF_SPLIT];
                cap_read_q <= pwdata[`DMCT_RF_CAP_READ];
                run_q <= pwdata[`DMCT_RF_RUN];
                low_ie_q <= pwdata[`DMCT_RF_LOW_IE];
            end
            if (hit_capture) begin
                cap_sel_q <= pwdata[`DMCT_CC_SEL_HI:`DMCT_CC_SEL_LO];
                cap_ie_q <= pwdata[`DMCT_CC_IE];
            end
            if (hit_clock) begin
                src_q <= dmct_pkg::dmct_src_t'(pwdata[`DMCT_CK_SRC_HI:`DMCT_CK_SRC_LO]);
                evt_pin_q <= pwdata[`DMCT_CK_EVT_PIN];
                limit_q <= pwdata[`DMCT_CK_LIMIT_HI:`DMCT_CK_LIMIT_LO];
            end
        end
    end

    // timer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= `DMCT_RST_PRE;
            cnt_l_q <= `DMCT_RST_BYTE;
            cnt_h_q <= `DMCT_RST_BYTE;
            buf_l_q <= `DMCT_RST_BYTE;
            buf_h_q <= `DMCT_RST_BYTE;
            {low_flag_q, high_flag_q, low_cflag_q, high_cflag_q, irq} <= 5'h00;
        end else begin
            pre_q <= pre_d;
            cnt_l_q <= cnt_l_d;
            cnt_h_q <= cnt_h_d;
            buf_l_q <= buf_l_d;
            buf_h_q <= buf_h_d;
            low_flag_q <= low_flag_d;
            high_flag_q <= high_flag_d;
            low_cflag_q <= low_cflag_d;
            high_cflag_q <= high_cflag_d;
            irq <= irq_d;
        end
    end

    // capture registers hold the counter as it stood at the event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_l_q <= `DMCT_RST_BYTE;
            cap_h_q <= `DMCT_RST_BYTE;
        end else begin
            if (cap_l_evt) begin
                cap_l_q <= cnt_l_q; // [R12] [R14]
            end
            if (cap_h_evt) begin
                cap_h_q <= cnt_h_q; // [R13] [R14]
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pre_stop;
        !pre_run |=> pre_q == '0;
    endproperty
    a_pre_stop: assert property (p_pre_stop) else $error("prescaler not cleared"); // [R1]

    property p_pre_gate;
        (!split_q && !run_q) |-> !pre_run && !pre_match;
    endproperty
    a_pre_gate: assert property (p_pre_gate) else $error("prescaler ran in stop"); // [R2]

    // two stopped cycles: a run written in the second may match at once with zero data
    property p_low_stop;
        (!run_q) [*2] |-> cnt_l_q == '0 && !low_match;
    endproperty
    a_low_stop: assert property (p_low_stop) else $error("low counter ran stopped"); // [R4]

    property p_high_split;
        (split_q && !high_run_q) [*2] |-> cnt_h_q == '0;
    endproperty
    a_high_split: assert property (p_high_split) else $error("high byte ran"); // [R5]

    property p_low_wrap;
        (split_q && low_adv && cnt_l_q == buf_l_q) |=> cnt_l_q == '0 && low_flag_q;
    endproperty
    a_low_wrap: assert property (p_low_wrap) else $error("low did not wrap"); // [R8] [R19]

    property p_buf_track;
        !low_run |=> buf_l_q == $past(low_data_q);
    endproperty
    a_buf_track: assert property (p_buf_track) else $error("buffer not tracking"); // [R9]

    property p_cap16;
        (!split_q && cap_l_evt) |=> cap_l_q == $past(cnt_l_q) && cap_h_q == $past(cnt_h_q)
            && low_cflag_q;
    endproperty
    a_cap16: assert property (p_cap16) else $error("joint capture lost"); // [R14] [R21]

    property p_irq;
        (low_flag_q && low_ie_q) || (cap_ie_q && high_cflag_q) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // [R17] [R18] [R23]

    property p_read_cap;
        (rd_setup && hit_count_low && cap_read_q) |=> prdata[7:0] == $past(cap_l_q);
    endproperty
    a_read_cap: assert property (p_read_cap) else $error("capture read wrong"); // [R20]

endmodule // dmct_timer

// ### testbench/dmct_timer_tb.sv
// self-checking bench for the dual mode capture timer over apb
`include "dmct_consts.svh"

module dmct_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [14:0] idx_lm = `DMCT_IDX_LOW_MATCH;
    localparam logic [14:0] idx_hm = `DMCT_IDX_HIGH_MATCH;
    localparam logic [14:0] idx_cl = `DMCT_IDX_COUNT_LOW;
    localparam logic [14:0] idx_rf = `DMCT_IDX_RUN_FLAG;
    localparam logic [14:0] idx_cc = `DMCT_IDX_CAPTURE;
    localparam logic [14:0] idx_ck = `DMCT_IDX_CLOCK;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [16:0] paddr = 17'h0_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [5:0] pins = 6'h00;
    logic xtal = 1'b0;
    logic cer = 1'b0;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    logic [14:0] idx_t[7] = '{15'h7e18, 15'h7e19, 15'h7f1a, 15'h7f1b, 15'h7f1c, 15'h7f1d,
        15'h7f1e};
    logic [7:0] ck_t[6] = '{8'h01, 8'h03, 8'h03, 8'h80, 8'hc0, 8'h43};
    logic [7:0] lm_t[6] = '{8'h05, 8'h00, 8'h04, 8'h04, 8'h04, 8'h00};
    logic [7:0] hm_t[6] = '{8'h01, 8'h09, 8'h00, 8'h00, 8'h00, 8'h09};
    logic [7:0] rf_t[6] = '{8'h05, 8'hb0, 8'h15, 8'h15, 8'h15, 8'hb0};
    int per_t[6] = '{524, 40, 20, 20, 30, 40};
    int lp[4] = '{0, 2, 4, 5};
    int hp[4] = '{1, 3, 5, 4};

    dmct_timer dmct_timer_inst (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ext_event_pin_a(pins[0]),
        .ext_event_pin_b(pins[1]),
        .ext_event_pin_c(pins[2]),
        .ext_event_pin_d(pins[3]),
        .ext_event_pin_e(pins[4]),
        .ext_event_pin_f(pins[5]),
        .crystal_clock_src(xtal),
        .ceramic_clock_src(cer),
        .irq(irq)
    );

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic test_done();
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // oscillators run well below pclk/2 so every tick is seen as an edge
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1) xtal <= ~xtal;
        if (cyc % 3 == 2) cer <= ~cer;
        if (cyc > 20000) begin
            fails++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; the trailing idle edge keeps psel from being driven twice per step
    task automatic apb(input logic w, input logic [14:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count is assumed; only the bench timeout ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [14:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [14:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h00_0000, exp}, what);
    endtask

    // pin pulse long enough for the synchroniser, then settle time
    task automatic pulse(input int i);
        pins[i] <= 1'b1;
        repeat (3) @(posedge pclk);
        pins[i] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        chk(irq, v, "irq level");
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rdc(idx_t[i], 8'h00, "reset value");
        apb(1'b0, 15'h7f1f, 8'h00);
        chk(rd, 32'h0000_0000, "unmapped read");
        chk(err, 1'b1, "unmapped error");
        chk(pready, 1'b1, "pready");
        wr(idx_cl, 8'h55);
        rdc(idx_cl, 8'h00, "read-only count");
        pstrb <= 4'h0;
        wr(idx_lm, 8'haa);
        pstrb <= 4'h1;
        rdc(idx_lm, 8'h00, "strobe off write");
        // period per mode and clock source, measured between irq rises
        for (int r = 0; r < 6; r++) begin
            wr(idx_rf, 8'h00);
            wr(idx_lm, lm_t[r]);
            wr(idx_hm, hm_t[r]);
            wr(idx_ck, ck_t[r]);
            wr(idx_rf, rf_t[r]);
            wait_irq(1'b1);
            t0 = cyc;
            wr(idx_rf, rf_t[r]);
            wait_irq(1'b0);
            wait_irq(1'b1);
            chk(cyc - t0, per_t[r], "period");
        end
        wr(idx_rf, 8'h00);
        wr(idx_ck, 8'h00);
        wr(idx_rf, 8'h80);
        repeat (20) @(posedge pclk);
        rdc(idx_cl, 8'h00, "16-bit high run only");
        wr(idx_rf, 8'h00);
        wr(idx_ck, 8'h40);
        wr(idx_lm, 8'h03);
        wr(idx_rf, 8'h14);
        for (int i = 0; i < 3; i++) pulse(2);
        rdc(idx_cl, 8'h03, "event count");
        wr(idx_cc, 8'h01);
        pulse(0);
        rdc(idx_cc, 8'h03, "capture flag");
        chk(irq, 1'b1, "capture irq");
        pulse(2);
        rdc(idx_rf, 8'h16, "event wrap flag");
        wr(idx_rf, 8'h1c);
        rdc(idx_cl, 8'h03, "capture read");
        wr(idx_rf, 8'h14);
        rdc(idx_cl, 8'h00, "live read");
        // each trigger code: low pin sets only the low flag, high pin only the high flag
        for (int k = 0; k < 4; k++) begin
            wr(idx_cc, 8'(k << 3));
            pulse(lp[k]);
            rdc(idx_cc, 8'((k << 3) | 2), "low trigger");
            wr(idx_cc, 8'(k << 3));
            pulse(hp[k]);
            rdc(idx_cc, 8'((k << 3) | 4), "high trigger");
        end
        wr(idx_rf, 8'h00);
        wr(idx_cc, 8'h00);
        pulse(0);
        rdc(idx_cc, 8'h02, "joint capture flag");
        chk(irq, 1'b0, "capture irq masked");
        // 16-bit event counting through the prescaler, third pin then second pin
        wr(idx_rf, 8'h00);
        wr(idx_ck, 8'h60);
        wr(idx_lm, 8'h05);
        wr(idx_rf, 8'h04);
        pulse(3);
        pulse(3);
        pulse(2);
        rdc(idx_cl, 8'h02, "third pin events");
        wr(idx_ck, 8'h40);
        pulse(2);
        pulse(3);
        rdc(idx_cl, 8'h03, "second pin events");
        test_done();
    end
endmodule // dmct_timer_tb
